// ---- shared/alarm_status_pkg.sv ----
// Shared register map, field layout and reset values of the alarm status bank
package alarm_status_pkg;

   // ----------------------------------------------------------------
   // Register offsets on the serial management port
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_IRQ_ENABLES     = 16'h00c7;
   localparam logic [15:0] ADDR_ENABLE_RSVD     = 16'h00c8;
   localparam logic [15:0] ADDR_STICKY_FLAGS    = 16'h0200;
   localparam logic [15:0] ADDR_STATUS_RSVD_A   = 16'h0201;
   localparam logic [15:0] ADDR_STATUS_RSVD_B   = 16'h0202;
   localparam logic [15:0] ADDR_STATUS_RSVD_C   = 16'h0203;
   localparam logic [15:0] ADDR_PHASE_BUSY      = 16'h0204;
   localparam logic [15:0] ADDR_LOOP0_REF       = 16'h0205;
   localparam logic [15:0] ADDR_LOOP1_REF       = 16'h020f;
   localparam logic [15:0] ADDR_GENERAL_INPUTS  = 16'h0219;
   localparam logic [15:0] ADDR_GLOBAL_IRQ      = 16'h021a;
   localparam logic [15:0] ADDR_BOOT_FAIL       = 16'h021e;
   localparam logic [15:0] ADDR_LOAD_STATUS     = 16'h021f;

   // ----------------------------------------------------------------
   // Field layout of the enable byte and the sticky flag byte
   // ----------------------------------------------------------------
   localparam int LOCK_LOSS_LSB   = 6;   // Bits 7:6, loop 1 on top
   localparam int HOLDOVER_LSB    = 4;   // Bits 5:4, loop 1 on top
   localparam int SIGNAL_LOSS_LSB = 0;   // Bits 3:0, reference 3 on top

   // Loop status byte: feedback-lost bit and selected reference field
   localparam int FEEDBACK_LOST_BIT = 4;
   localparam int SELECTED_REF_LSB  = 0;

   // Global and load status bit positions
   localparam int GLOBAL_IRQ_BIT    = 0;
   localparam int BOOT_FAIL_BIT     = 0;
   localparam int CHECK_OK_N_BIT    = 3;
   localparam int LOAD_DONE_BIT     = 0;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] ENABLES_RESET   = 8'h00;
   localparam logic [7:0] FLAGS_RESET     = 8'h00;
   localparam logic [7:0] RESERVED_READ   = 8'h00;
   localparam logic [2:0] NO_REF_CODE     = 3'h0;   // Any of 000..011 means none
   localparam logic       REF_SELECT_MARK = 1'b1;   // Top bit marks a selection

   // Read-back state of a register access
   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b01,
      ACC_REPLY = 2'b10
   } access_state_t;

endpackage : alarm_status_pkg

// ---- rtl/sticky_flag_bank.sv ----
// Sticky write-one-to-clear flag bank with set priority
`timescale 1ns/10ps
module sticky_flag_bank
   import alarm_status_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             clock_in,
   input  wire logic             sys_rst_in,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   output logic      [WIDTH-1:0] flags_out
);

   // ----------------------------------------------------------------
   // Flag storage
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   // Set beats clear so an alarm in the clearing cycle is never lost
   always_comb
   begin
      flags_d = (flags_q & ~clear_in) | set_in;   // RL5 RL6 RL7 RL21
   end

   // Flags hold until acknowledged; reset starts them all clear
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         flags_q <= WIDTH'(FLAGS_RESET);   // RL22
      else
         flags_q <= flags_d;
   end

   assign flags_out = flags_q;

endmodule : sticky_flag_bank

// ---- rtl/config_load_status.sv ----
// Latches the outcome of the configuration memory load until reset
`timescale 1ns/10ps
module config_load_status
   import alarm_status_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic load_failed_in,
   input  wire logic load_done_in,
   input  wire logic check_failed_in,
   output logic      config_load_failed_out,
   output logic      config_load_done_out,
   output logic      config_check_ok_n_out,
   output logic      port_locked_out
);

   // ----------------------------------------------------------------
   // Load outcome latches
   // ----------------------------------------------------------------
   logic failed_q;
   logic done_q;
   logic check_bad_q;

   // Only a reset clears these, so software cannot hide a bad boot
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         failed_q    <= 1'b0;
         done_q      <= 1'b0;
         check_bad_q <= 1'b0;
      end
      else
      begin
         failed_q    <= failed_q | load_failed_in;      // RL18
         done_q      <= done_q | load_done_in;          // RL19
         check_bad_q <= check_bad_q | check_failed_in;  // RL20
      end
   end

   assign config_load_failed_out = failed_q;
   assign config_load_done_out   = done_q;
   assign config_check_ok_n_out  = ~check_bad_q;  // RL20
   assign port_locked_out        = check_bad_q;   // RL20

endmodule : config_load_status

// ---- rtl/alarm_interrupt_status_bank.sv ----
// Alarm enables, sticky alarm flags, status readback and interrupt pin
// Notes on behaviour
// RL1: Lock-loss flag reaches the interrupt pin only while its enable is one.
// RL2: Holdover flag reaches the interrupt pin only while its enable is one.
// RL3: Signal-loss flag of each reference reaches the pin only when enabled.
// RL4: Enable byte order: lock-loss 1,0, holdover 1,0, signal-loss 3..0.
// RL5: Any lock-loss, holdover or signal-loss alarm sets its flag.
// RL6: A flag stays set after its alarm goes away.
// RL7: Writing one to a flag bit is the only way to clear it; the code also clears every flag on reset.
// RL8: Holdover flag reads one if a holdover alarm happened since clearing.
// RL9: Signal-loss flag reads one if such an alarm happened since clearing.
// RL10: Host writes zero to reserved bits and ignores their read value.
// RL11: One read-only busy bit per output while phase adjustment runs.
// RL12: Host starts no phase adjustment on an output while it is busy.
// RL13: Selected-reference field codes 000 to 011 mean no reference selected.
// RL14: References 0 to 3 are encoded as 100, 101, 110 and 111.
// RL15: Feedback-lost bit per loop is one while its feedback is lost.
// RL16: General input byte shows present levels of the eight input pins.
// RL17: Global interrupt bit and low pin whenever any enabled flag is set.
// RL18: Boot-failure bit sets on a failed memory load, reset clears it.
// RL19: Load-complete bit sets when the memory load ends, reset clears it.
// RL20: Check-error bit low on failed memory check, port locked until reset.
// RL21: Writing zero to a flag bit leaves it unchanged.
// RL22: Reset leaves enables and flags at zero, pin released.
`timescale 1ns/10ps
module alarm_interrupt_status_bank
   import alarm_status_pkg::*;
#(
   parameter int LOOPS   = 2,
   parameter int REFS    = 4,
   parameter int OUTPUTS = 8,
   parameter int GPIS    = 8
)
(
   input  wire logic               clock_in,
   input  wire logic               sys_rst_in,
   // Register access from the serial management port engine
   input  wire logic [15:0]        reg_addr_in,
   input  wire logic               reg_wr_in,
   input  wire logic [7:0]         reg_wdata_in,
   input  wire logic               reg_rd_in,
   output logic      [7:0]         reg_rdata_out,
   output logic                    reg_rvalid_out,
   // Alarm events from the loops and input monitors
   input  wire logic [LOOPS-1:0]   lock_loss_alarm_in,
   input  wire logic [LOOPS-1:0]   holdover_alarm_in,
   input  wire logic [REFS-1:0]    signal_loss_alarm_in,
   // Live status from the loops, phase adjuster and pins
   input  wire logic [OUTPUTS-1:0] phase_adjust_busy_in,
   input  wire logic [LOOPS-1:0]   loop_ref_valid_in,
   input  wire logic [1:0]         loop0_ref_index_in,
   input  wire logic [1:0]         loop1_ref_index_in,
   input  wire logic               loop0_feedback_lost_in,
   input  wire logic               loop1_feedback_lost_in,
   input  wire logic [GPIS-1:0]    general_input_level_in,
   // Configuration memory loader outcome
   input  wire logic               config_load_failed_in,
   input  wire logic               config_load_done_in,
   input  wire logic               config_check_failed_in,
   // Open-drain interrupt pin and port lock
   output logic                    irq_pin_n_out,
   output logic                    irq_pin_n_oe_out,
   output logic                    serial_port_locked_out
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Selected-reference code: top bit marks a selection, low bits index
   function automatic logic [2:0] encode_ref(input logic valid, input logic [1:0] index);
      logic [2:0] code;
      code = NO_REF_CODE;                          // RL13
      if (valid)
         code = {REF_SELECT_MARK, index};           // RL14
      return code;
   endfunction : encode_ref

   // Pack one loop status byte, reserved bits reading zero
   function automatic logic [7:0] loop_byte(input logic lost, input logic [2:0] code);
      logic [7:0] b;
      b = RESERVED_READ;
      b[FEEDBACK_LOST_BIT] = lost;                  // RL15
      b[SELECTED_REF_LSB +: 3] = code;
      return b;
   endfunction : loop_byte

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic       port_locked;
   logic       wr_ok;
   logic       enables_wr;
   logic       flags_wr;

   // A locked port takes no writes; reads still answer
   assign wr_ok      = reg_wr_in & ~port_locked;   // RL20
   assign enables_wr = wr_ok & (reg_addr_in == ADDR_IRQ_ENABLES);
   assign flags_wr   = wr_ok & (reg_addr_in == ADDR_STICKY_FLAGS);

   // ----------------------------------------------------------------
   // Interrupt enable register
   // ----------------------------------------------------------------
   logic [7:0] irq_enables_q;
   logic [LOOPS-1:0] lock_loss_irq_enable;
   logic [LOOPS-1:0] holdover_irq_enable;
   logic [REFS-1:0]  signal_loss_irq_enable;

   // Plain read/write byte; reserved neighbour is not stored
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         irq_enables_q <= ENABLES_RESET;   // RL22
      else if (enables_wr)
         irq_enables_q <= reg_wdata_in;
   end

   // Field split of the enable byte
   assign lock_loss_irq_enable   = irq_enables_q[LOCK_LOSS_LSB +: LOOPS];    // RL4
   assign holdover_irq_enable    = irq_enables_q[HOLDOVER_LSB +: LOOPS];     // RL4
   assign signal_loss_irq_enable = irq_enables_q[SIGNAL_LOSS_LSB +: REFS];   // RL4

   // ----------------------------------------------------------------
   // Sticky alarm flags
   // ----------------------------------------------------------------
   logic [7:0] alarm_set;
   logic [7:0] alarm_clear;
   logic [7:0] sticky_flags;
   logic [LOOPS-1:0] lock_loss_flag;
   logic [LOOPS-1:0] holdover_flag;
   logic [REFS-1:0]  signal_loss_flag;

   // Alarms laid out in the same order as the enables
   always_comb
   begin
      alarm_set = 8'h00;
      alarm_set[LOCK_LOSS_LSB +: LOOPS]  = lock_loss_alarm_in;     // RL5
      alarm_set[HOLDOVER_LSB +: LOOPS]   = holdover_alarm_in;      // RL5 RL8
      alarm_set[SIGNAL_LOSS_LSB +: REFS] = signal_loss_alarm_in;   // RL5 RL9
   end

   // Only ones in the written byte clear; zeros leave flags alone
   assign alarm_clear = flags_wr ? reg_wdata_in : 8'h00;   // RL7 RL21

   sticky_flag_bank #(
      .WIDTH      (8)
   ) u_flags (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .set_in     (alarm_set),
      .clear_in   (alarm_clear),
      .flags_out  (sticky_flags)
   );

   assign lock_loss_flag   = sticky_flags[LOCK_LOSS_LSB +: LOOPS];
   assign holdover_flag    = sticky_flags[HOLDOVER_LSB +: LOOPS];
   assign signal_loss_flag = sticky_flags[SIGNAL_LOSS_LSB +: REFS];

   // ----------------------------------------------------------------
   // Interrupt summary and pin
   // ----------------------------------------------------------------
   logic irq_active_q;
   logic irq_active_d;

   // Each flag is gated by its own enable before the summary
   always_comb
   begin
      irq_active_d = |(lock_loss_flag & lock_loss_irq_enable)      // RL1
                   | |(holdover_flag & holdover_irq_enable)        // RL2
                   | |(signal_loss_flag & signal_loss_irq_enable); // RL3
   end

   // Registered so the pin never glitches on flag and enable skew
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         irq_active_q <= 1'b0;   // RL22
      else
         irq_active_q <= irq_active_d;   // RL17
   end

   // Open drain: only ever pulls low, released otherwise
   assign irq_pin_n_out    = 1'b0;
   assign irq_pin_n_oe_out = irq_active_q;   // RL17

   // ----------------------------------------------------------------
   // Configuration load status
   // ----------------------------------------------------------------
   logic config_load_failed;
   logic config_load_done;
   logic config_check_ok_n;

   config_load_status u_load (
      .clock_in               (clock_in),
      .sys_rst_in             (sys_rst_in),
      .load_failed_in         (config_load_failed_in),
      .load_done_in           (config_load_done_in),
      .check_failed_in        (config_check_failed_in),
      .config_load_failed_out (config_load_failed),
      .config_load_done_out   (config_load_done),
      .config_check_ok_n_out  (config_check_ok_n),
      .port_locked_out        (port_locked)
   );

   assign serial_port_locked_out = port_locked;

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [7:0] read_mux;
   logic [2:0] loop0_selected_ref;
   logic [2:0] loop1_selected_ref;

   assign loop0_selected_ref = encode_ref(loop_ref_valid_in[0], loop0_ref_index_in);
   assign loop1_selected_ref = encode_ref(loop_ref_valid_in[1], loop1_ref_index_in);

   // Reserved and unmapped offsets read zero; host must not rely on them
   always_comb
   begin
      read_mux = RESERVED_READ;   // RL10
      case (reg_addr_in)
         ADDR_IRQ_ENABLES:    read_mux = irq_enables_q;
         ADDR_STICKY_FLAGS:   read_mux = sticky_flags;
         ADDR_PHASE_BUSY:     read_mux = 8'(phase_adjust_busy_in);   // RL11
         ADDR_LOOP0_REF:      read_mux = loop_byte(loop0_feedback_lost_in, loop0_selected_ref);
         ADDR_LOOP1_REF:      read_mux = loop_byte(loop1_feedback_lost_in, loop1_selected_ref);
         ADDR_GENERAL_INPUTS: read_mux = 8'(general_input_level_in); // RL16
         ADDR_GLOBAL_IRQ:     read_mux[GLOBAL_IRQ_BIT] = irq_active_q; // RL17
         ADDR_BOOT_FAIL:      read_mux[BOOT_FAIL_BIT] = config_load_failed; // RL18
         ADDR_LOAD_STATUS:
         begin
            read_mux[CHECK_OK_N_BIT] = config_check_ok_n;   // RL20
            read_mux[LOAD_DONE_BIT]  = config_load_done;    // RL19
         end
         default:             read_mux = RESERVED_READ;
      endcase
   end

   // ----------------------------------------------------------------
   // Read reply
   // ----------------------------------------------------------------
   access_state_t acc_state_q;
   logic [7:0]    rdata_q;

   // One-cycle reply: data captured at the read edge, shown next cycle
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         acc_state_q <= ACC_IDLE;
         rdata_q     <= 8'h00;
      end
      else
      begin
         case (acc_state_q)
            ACC_IDLE:
            begin
               if (reg_rd_in)
               begin
                  acc_state_q <= ACC_REPLY;
                  rdata_q     <= read_mux;
               end
            end
            ACC_REPLY:
            begin
               // Back-to-back reads are served without a gap
               if (reg_rd_in)
                  rdata_q <= read_mux;
               else
                  acc_state_q <= ACC_IDLE;
            end
            default:
               acc_state_q <= ACC_IDLE;
         endcase
      end
   end

   assign reg_rdata_out  = rdata_q;
   assign reg_rvalid_out = (acc_state_q == ACC_REPLY);

endmodule : alarm_interrupt_status_bank

// ---- tb/alarm_bank_sva.sv ----
// Concurrent checks on the ports of the alarm status bank
`timescale 1ns/10ps
module alarm_bank_sva
   import alarm_status_pkg::*;
#(parameter int LOOPS = 2, REFS = 4, OUTPUTS = 8, GPIS = 8)
(
   input wire logic               clock_in,
   input wire logic               sys_rst_in,
   input wire logic [15:0]        reg_addr_in,
   input wire logic               reg_rd_in,
   input wire logic [7:0]         reg_rdata_out,
   input wire logic               reg_rvalid_out,
   input wire logic [LOOPS-1:0]   lock_loss_alarm_in,
   input wire logic [LOOPS-1:0]   holdover_alarm_in,
   input wire logic [REFS-1:0]    signal_loss_alarm_in,
   input wire logic [OUTPUTS-1:0] phase_adjust_busy_in,
   input wire logic [LOOPS-1:0]   loop_ref_valid_in,
   input wire logic [1:0]         loop0_ref_index_in,
   input wire logic               loop0_feedback_lost_in,
   input wire logic [GPIS-1:0]    general_input_level_in,
   input wire logic               config_check_failed_in,
   input wire logic               irq_pin_n_out,
   input wire logic               irq_pin_n_oe_out,
   input wire logic               serial_port_locked_out
);
   logic [1:0] age_q;
   logic [7:0] alarm_vec;

   // Edges since reset; the flag check looks two cycles back
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         age_q <= 2'h0;
      else if (age_q != 2'h3)
         age_q <= age_q + 2'h1;
   end

   // Alarms in flag byte order
   assign alarm_vec = {lock_loss_alarm_in, holdover_alarm_in, signal_loss_alarm_in};

   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   sequence flag_read;
      age_q == 2'h3 && reg_rd_in && reg_addr_in == ADDR_STICKY_FLAGS;
   endsequence
   sequence sel_read(logic [15:0] a);
      reg_rd_in && reg_addr_in == a;
   endsequence

   a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read got no answer");
   a_no_stray_answer: assert property (!reg_rd_in |=> !reg_rvalid_out)
      else $error("answer without read");
   a_pin_data_low: assert property (irq_pin_n_out == 1'b0)
      else $error("interrupt pin data not low");
   a_reset_releases_pin: assert property ($fell(sys_rst_in) |-> !irq_pin_n_oe_out)
      else $error("pin held after reset");
   a_global_mirrors_pin: assert property (sel_read(ADDR_GLOBAL_IRQ) |=>
      reg_rdata_out == {7'h00, $past(irq_pin_n_oe_out)}) else $error("global bit off");
   a_alarm_sets_flag: assert property (flag_read |=>
      (reg_rdata_out & $past(alarm_vec, 2)) == $past(alarm_vec, 2)) else $error("flag missed");
   a_busy_live: assert property (sel_read(ADDR_PHASE_BUSY) |=>
      reg_rdata_out == $past(phase_adjust_busy_in)) else $error("busy byte wrong");
   a_inputs_live: assert property (sel_read(ADDR_GENERAL_INPUTS) |=>
      reg_rdata_out == $past(general_input_level_in)) else $error("input byte wrong");
   a_loop_code: assert property (sel_read(ADDR_LOOP0_REF) |=>
      reg_rdata_out == {3'h0, $past(loop0_feedback_lost_in), 1'b0,
      ($past(loop_ref_valid_in[0]) ? {1'b1, $past(loop0_ref_index_in)} : 3'h0)})
      else $error("loop status wrong");
   a_lock_follows: assert property (config_check_failed_in |=>
      ##[0:1] serial_port_locked_out [*3]) else $error("port not locked");
endmodule : alarm_bank_sva

bind alarm_interrupt_status_bank alarm_bank_sva #(.LOOPS(LOOPS), .REFS(REFS),
   .OUTPUTS(OUTPUTS), .GPIS(GPIS)) u_sva (.clock_in, .sys_rst_in, .reg_addr_in,
   .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .lock_loss_alarm_in, .holdover_alarm_in,
   .signal_loss_alarm_in, .phase_adjust_busy_in, .loop_ref_valid_in, .loop0_ref_index_in,
   .loop0_feedback_lost_in, .general_input_level_in, .config_check_failed_in,
   .irq_pin_n_out, .irq_pin_n_oe_out, .serial_port_locked_out);

// ---- tb/alarm_host_model.sv ----
// Host model speaking the register port of the alarm status bank
`timescale 1ns/10ps
module alarm_host_model
(
   input  wire logic        clock_in,
   input  wire logic [7:0]  reg_rdata_in,
   input  wire logic        reg_rvalid_in,
   output logic      [15:0] reg_addr_out,
   output logic             reg_wr_out,
   output logic      [7:0]  reg_wdata_out,
   output logic             reg_rd_out
);
   // Idle bus: strobes low, address and data parked on junk
   initial
   begin
      reg_addr_out = 16'hffff;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h5a;
      reg_rd_out = 1'b0;
   end

   // One-cycle write; flags are acknowledged by ones, reserved places get zero
   task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
      @(posedge clock_in);
      #1;
      reg_addr_out = addr;
      reg_wdata_out = data;
      reg_wr_out = 1'b1;
      @(posedge clock_in);
      #1;
      reg_wr_out = 1'b0;
      reg_addr_out = ~addr;
      reg_wdata_out = ~data;
   endtask : write_reg

   // One-cycle read; the answer is taken at the edge after the strobe
   task automatic read_reg(input logic [15:0] addr, output logic [7:0] data);
      @(posedge clock_in);
      #1;
      reg_addr_out = addr;
      reg_rd_out = 1'b1;
      @(posedge clock_in);
      #1;
      reg_rd_out = 1'b0;
      reg_addr_out = ~addr;
      @(posedge clock_in);
      data = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hxx;
      #1;
   endtask : read_reg
endmodule : alarm_host_model

// ---- tb/tb.sv ----
// Self-checking testbench for the alarm status bank
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   import alarm_status_pkg::*;
   logic        clock_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [7:0]  alarm_vec = 8'h00;
   logic [7:0]  busy = 8'h00;
   logic [7:0]  general_input_levels = 8'h00;
   logic [1:0]  valid = 2'h0;
   logic [1:0]  idx0 = 2'h0;
   logic [1:0]  idx1 = 2'h0;
   logic        fb0 = 1'b0;
   logic        fb1 = 1'b0;
   logic        cfg_fail = 1'b0;
   logic        cfg_done = 1'b0;
   logic        cfg_bad = 1'b0;
   wire  [15:0] addr;
   wire         wr, rd, rvalid, pin_n, pin_oe, locked;
   wire  [7:0]  wdata, rdata;
   int          miscompares = 0;
   int          checks = 0;

   always #4 clock_in = ~clock_in;

   alarm_interrupt_status_bank dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .lock_loss_alarm_in(alarm_vec[7:6]),
      .holdover_alarm_in(alarm_vec[5:4]), .signal_loss_alarm_in(alarm_vec[3:0]),
      .phase_adjust_busy_in(busy), .loop_ref_valid_in(valid), .loop0_ref_index_in(idx0),
      .loop1_ref_index_in(idx1), .loop0_feedback_lost_in(fb0), .loop1_feedback_lost_in(fb1),
      .general_input_level_in(general_input_levels), .config_load_failed_in(cfg_fail),
      .config_load_done_in(cfg_done), .config_check_failed_in(cfg_bad),
      .irq_pin_n_out(pin_n), .irq_pin_n_oe_out(pin_oe), .serial_port_locked_out(locked));

   alarm_host_model host (.clock_in(clock_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
      .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.read_reg(a, d);
      `CHK(d, e)
   endtask : rchk

   // The pin follows a flag change one edge later; the check waits two edges
   task automatic pin_chk(input logic e);
      repeat (2) @(posedge clock_in);
      #1;
      `CHK(pin_oe, e)
   endtask : pin_chk

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge clock_in);
      #1;
      s = 1'b0;
   endtask : pulse

   task automatic do_reset();
      sys_rst_in = 1'b1;
      repeat (10) @(posedge clock_in);
      #1;
      sys_rst_in = 1'b0;
   endtask : do_reset

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // -------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------
   initial
   begin
      do_reset();
      rchk(ADDR_IRQ_ENABLES, ENABLES_RESET);
      rchk(ADDR_STICKY_FLAGS, FLAGS_RESET);
      `CHK(pin_oe, 1'b0)
      rchk(ADDR_ENABLE_RSVD, RESERVED_READ);
      rchk(ADDR_STATUS_RSVD_B, RESERVED_READ);
      rchk(16'h0300, 8'h00);
      rchk(ADDR_LOAD_STATUS, 8'h08);
      // Each alarm alone: sticky, masked by the others' enables, then cleared
      for (int i = 0; i < 8; i++)
      begin
         // Alarm still high across the read edge, so the flag checker sees it
         alarm_vec = 8'h01 << i;
         rchk(ADDR_STICKY_FLAGS, 8'h01 << i);
         alarm_vec = 8'h00;
         rchk(ADDR_STICKY_FLAGS, 8'h01 << i);
         host.write_reg(ADDR_IRQ_ENABLES, ~(8'h01 << i));
         pin_chk(1'b0);
         host.write_reg(ADDR_IRQ_ENABLES, 8'h01 << i);
         pin_chk(1'b1);
         rchk(ADDR_GLOBAL_IRQ, 8'h01);
         host.write_reg(ADDR_STICKY_FLAGS, 8'h00);
         rchk(ADDR_STICKY_FLAGS, 8'h01 << i);
         host.write_reg(ADDR_STICKY_FLAGS, 8'h01 << i);
         pin_chk(1'b0);
         rchk(ADDR_GLOBAL_IRQ, 8'h00);
      end
      // Busy is only read back; the bench never starts an adjustment
      busy = 8'ha5;
      general_input_levels = 8'h3c;
      rchk(ADDR_PHASE_BUSY, 8'ha5);
      rchk(ADDR_GENERAL_INPUTS, 8'h3c);
      // Every reference code on each loop, the other loop unselected
      for (int k = 0; k < 4; k++)
      begin
         idx0 = k[1:0];
         idx1 = 2'h3 - k[1:0];
         valid = 2'b01;
         {fb1, fb0} = 2'b01;
         rchk(ADDR_LOOP0_REF, 8'h14 | 8'(k));
         rchk(ADDR_LOOP1_REF, 8'h00);
         valid = 2'b10;
         {fb1, fb0} = 2'b10;
         rchk(ADDR_LOOP0_REF, 8'h00);
         rchk(ADDR_LOOP1_REF, 8'h17 - 8'(k));
      end
      pulse(cfg_done);
      rchk(ADDR_LOAD_STATUS, 8'h09);
      pulse(cfg_fail);
      rchk(ADDR_BOOT_FAIL, 8'h01);
      pulse(cfg_bad);
      rchk(ADDR_LOAD_STATUS, 8'h01);
      `CHK(locked, 1'b1)
      host.write_reg(ADDR_IRQ_ENABLES, 8'hff);
      // Enables keep the last value written before the port locked
      rchk(ADDR_IRQ_ENABLES, 8'h80);
      do_reset();
      rchk(ADDR_BOOT_FAIL, 8'h00);
      rchk(ADDR_LOAD_STATUS, 8'h08);
      `CHK(locked, 1'b0)
      wrap_up();
   end

   // Tests need about 350 cycles; give them over a hundred times that
   initial
   begin
      #320000;
      miscompares++;
      wrap_up();
   end
endmodule : tb
